// *** verilog/i2c_bus_control_status.sv ***
// two-wire bus control and status logic behind an AXI4-Lite register slave
`include "i2c_ctl_map.svh"
module i2c_bus_control_status
  import i2c_ctl_pkg::*;
#(
  parameter int LOW_CYC = `LOW_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        scl_i,
  output wire logic        scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output wire logic        sda_o,
  output logic             sda_oe,
  output logic             transfer_irq
);
  logic    scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic    aw_hold, w_hold;
  byte_t   aw_addr, w_byte, sh, own_reg;
  logic    w_lane;
  logic    master_select, transmit_select, bus_busy, pin, arbitration_lost;
  logic    self_addressed, zero_addr_seen, last_rx_bit, ack_mode, al_word;
  logic    start_req, stop_req, addr_phase;
  logic [1:0]  port_function;
  logic [2:0]  word_length;
  logic [3:0]  bit_idx;
  logic [15:0] cnt;
  mstate_t     mstate, next_mstate;

  // wired-AND bus: the pins are only ever pulled low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // two-stage synchronisers, third stage for edge and condition detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_m, scl_s, scl_d} <= 3'b111;
      {sda_m, sda_s, sda_d} <= 3'b111;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end

  wire logic en        = (port_function == `PF_I2C);
  wire logic scl_rise  = en & scl_s & ~scl_d;
  wire logic scl_fall  = en & ~scl_s & scl_d;
  wire logic start_det = en & scl_s & scl_d & sda_d & ~sda_s;
  wire logic stop_det  = en & scl_s & scl_d & ~sda_d & sda_s;

  // axi write: address and data taken in either order, answered once both are in
  assign awready = ~aw_hold & ~bvalid;
  assign wready  = ~w_hold & ~bvalid;
  wire logic wr_go   = aw_hold & w_hold & ~bvalid;
  wire logic wr_map  = (aw_addr == `OFS_DATA) | (aw_addr == `OFS_CTLA) |
                       (aw_addr == `OFS_CTLB) | (aw_addr == `OFS_STAT) |
                       (aw_addr == `OFS_OWN);
  wire logic data_wr = wr_go & w_lane & (aw_addr == `OFS_DATA);
  wire logic ctla_wr = wr_go & w_lane & (aw_addr == `OFS_CTLA);
  wire logic ctlb_wr = wr_go & w_lane & (aw_addr == `OFS_CTLB);
  wire logic own_wr  = wr_go & w_lane & (aw_addr == `OFS_OWN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_hold, w_hold, bvalid} <= 3'b000;
      {aw_addr, w_byte, w_lane} <= 17'h00000;
      bresp <= `RESP_OK;
    end else begin
      if (awvalid & awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {awaddr[7:2], 2'b00};
      end
      if (wvalid & wready) begin
        w_hold <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (wr_go) begin
        {aw_hold, w_hold, bvalid} <= 3'b001;
        bresp <= wr_map ? `RESP_OK : `RESP_ERR;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // axi read: one cycle answer; a data buffer read also releases the clock
  assign arready = ~rvalid;
  wire logic  rd_go   = arvalid & arready;
  wire logic  data_rd = rd_go & (araddr[7:2] == 6'(`OFS_DATA >> 2));
  wire logic  data_acc = data_wr | data_rd;
  wire byte_t stat = {master_select, transmit_select, bus_busy, pin,
                      arbitration_lost, self_addressed, zero_addr_seen, last_rx_bit};
  wire logic [7:0] rd_a = {araddr[7:2], 2'b00};
  wire logic  rd_map = (rd_a == `OFS_DATA) | (rd_a == `OFS_CTLA) | (rd_a == `OFS_CTLB) |
                       (rd_a == `OFS_STAT) | (rd_a == `OFS_OWN);
  wire byte_t rd_byte = (rd_a == `OFS_DATA) ? sh :
                        (rd_a == `OFS_CTLA) ? {word_length, ack_mode, 4'h0} :
                        (rd_a == `OFS_CTLB) ? {stat[7:4], port_function, 2'b00} :
                        (rd_a == `OFS_STAT) ? stat :
                        (rd_a == `OFS_OWN)  ? own_reg : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OK;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_byte};
      rresp  <= rd_map ? `RESP_OK : `RESP_ERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {word_length, ack_mode} <= 4'(`CTLA_RST >> 4);
      own_reg       <= `OWN_RST;
      port_function <= `PF_RST;
    end else begin
      if (ctla_wr) {word_length, ack_mode} <= w_byte[7:4];
      if (own_wr) own_reg <= w_byte;
      if (ctlb_wr) port_function <= w_byte[3:2];
    end
  end

  // word framing: address words are always eight bits
  wire logic       address_ignore = own_reg[0];
  wire logic [3:0] nbits = (addr_phase | word_length == 3'd0) ? 4'd8 : {1'b0, word_length};
  wire logic [3:0] total = nbits + {3'b000, ack_mode};
  wire logic data_slot = bit_idx < nbits;
  wire logic ack_slot  = ack_mode & (bit_idx == nbits);
  wire logic shift_now = scl_fall & bus_busy & (bit_idx != 4'd0) & (bit_idx <= nbits);
  wire byte_t rx_word  = (scl_fall & bit_idx == nbits) ? {sh[6:0], last_rx_bit} : sh;
  wire logic addr_hit  = ~address_ignore & (rx_word[7:1] == own_reg[7:1]);
  wire logic gc_hit    = ~address_ignore & (rx_word == 8'h00);
  wire logic take = addr_phase ? (addr_hit | gc_hit | address_ignore) : self_addressed;
  wire logic word_done = scl_fall & bus_busy & (bit_idx == total);
  wire logic addr_phase_done = word_done & addr_phase;

  // a master in the address word always transmits
  wire logic master_tx = master_select & (addr_phase | transmit_select);
  wire logic slave_tx  = ~master_select & self_addressed & transmit_select & ~addr_phase;
  // our own low on SDA while a stop is being made is not a lost arbitration
  wire logic in_stop   = (mstate == M_STOP_A) | (mstate == M_STOP_B) | (mstate == M_STOP_C);
  wire logic al_ev = scl_rise & bus_busy & master_tx & data_slot & sh[7] & ~sda_s &
                     ~in_stop;
  wire logic irq_ev = word_done & (master_select | take);
  wire logic irq_nopin = addr_phase_done & ~master_select & al_word & ~take;
  wire logic start_cmd = ctlb_wr & (w_byte[7:4] == 4'hf) & ~bus_busy;
  wire logic stop_cmd  = ctlb_wr & (w_byte[7:4] == 4'hd) & bus_busy;

  // shift buffer, bit counter and address phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh         <= 8'h00;
      bit_idx    <= 4'h0;
      addr_phase <= 1'b0;
    end else begin
      if (data_wr) sh <= w_byte;
      else if (shift_now) sh <= {sh[6:0], last_rx_bit};
      if (start_det | word_done) bit_idx <= 4'h0;
      else if (scl_rise & bus_busy) bit_idx <= bit_idx + 4'h1;
      if (start_det) addr_phase <= ~address_ignore;
      else if (word_done | stop_det) addr_phase <= 1'b0;
    end
  end

  // sampled bus bit, doubles as the received acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) last_rx_bit <= 1'b0;
    else if (scl_rise) last_rx_bit <= sda_s;
  end

  // mode bits: hardware clears win over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_select   <= 1'b0;
      transmit_select <= 1'b0;
    end else if (stop_det | al_ev) begin
      master_select   <= 1'b0;
      transmit_select <= 1'b0;
    end else if (ctlb_wr) begin
      master_select   <= w_byte[`B_MST];
      transmit_select <= w_byte[`B_TRX];
    end else if (addr_phase_done & master_select & ack_mode & ~last_rx_bit) begin
      transmit_select <= ~rx_word[0];
    end else if (addr_phase_done & ~master_select & (addr_hit | gc_hit)) begin
      transmit_select <= rx_word[0];
    end
  end

  // bus state and service-pending bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_busy <= 1'b0;
      pin      <= `PIN_RST;
    end else begin
      if (start_det) bus_busy <= 1'b1;
      else if (stop_det) bus_busy <= 1'b0;
      // a software set wins so that a well-timed write is never lost
      if (data_acc | (ctlb_wr & w_byte[`B_PIN])) pin <= 1'b1;
      else if (irq_ev) pin <= 1'b0;
    end
  end

  // status flags: hardware set wins over the clearing access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {arbitration_lost, al_word, self_addressed, zero_addr_seen} <= 4'h0;
      transfer_irq <= 1'b0;
    end else begin
      if (al_ev) arbitration_lost <= 1'b1;
      else if (data_acc | ctlb_wr) arbitration_lost <= 1'b0;
      if (al_ev) al_word <= 1'b1;
      else if (start_det | word_done) al_word <= 1'b0;
      if (addr_phase_done & ~master_select & take) self_addressed <= 1'b1;
      else if (word_done & ~master_select & address_ignore & ~self_addressed)
        self_addressed <= 1'b1;
      else if (data_acc | start_det | stop_det) self_addressed <= 1'b0;
      if (start_det | stop_det) zero_addr_seen <= 1'b0;
      else if (addr_phase_done & ~master_select & gc_hit) zero_addr_seen <= 1'b1;
      transfer_irq <= irq_ev | irq_nopin;
    end
  end

  // master sequencer: start, clock pulses with stretching, stop
  wire logic cnt_done = (cnt == 16'(LOW_CYC));
  always_comb begin
    next_mstate = mstate;
    case (mstate)
      M_IDLE:   if (start_req & ~bus_busy) next_mstate = M_START;
      M_START:  if (cnt_done) next_mstate = M_LOW;
      M_LOW:    if (pin & cnt_done) next_mstate = stop_req ? M_STOP_A : M_HIGH;
      M_HIGH:   if (scl_s & cnt_done) next_mstate = M_LOW;
      M_STOP_A: if (cnt_done) next_mstate = M_STOP_B;
      M_STOP_B: if (scl_s & cnt_done) next_mstate = M_STOP_C;
      M_STOP_C: if (cnt_done | stop_det) next_mstate = M_IDLE;
      default:  next_mstate = M_IDLE;
    endcase
    if (al_ev | ~en) next_mstate = M_IDLE;
  end

  // the counter restarts on each state change and while the line is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mstate <= M_IDLE;
      cnt    <= 16'h0000;
    end else begin
      mstate <= next_mstate;
      if (next_mstate != mstate | ~pin | ((mstate == M_HIGH | mstate == M_STOP_B) & ~scl_s))
        cnt <= 16'h0000;
      else if (!cnt_done) cnt <= cnt + 16'h0001;
    end
  end

  // pending commands; each clears once the sequencer enters M_START or M_STOP_A, or on a lost arbitration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_req <= 1'b0;
      stop_req  <= 1'b0;
    end else begin
      if (start_cmd) start_req <= 1'b1;
      else if (mstate == M_START | al_ev | ~en) start_req <= 1'b0;
      if (stop_cmd) stop_req <= 1'b1;
      else if (mstate == M_STOP_A | al_ev | ~en) stop_req <= 1'b0;
    end
  end

  // pin drivers, registered so no decode glitch reaches the bus
  wire logic m_scl_low = (mstate == M_LOW) | (mstate == M_STOP_A);
  wire logic m_sda_low = (mstate == M_START) | (mstate == M_STOP_A) | (mstate == M_STOP_B);
  wire logic data_zero = data_slot & (master_tx | slave_tx) & ~sh[7];
  wire logic ack_zero  = ack_slot & (master_select ? (~addr_phase & ~transmit_select)
                                                   : (take & (addr_phase | ~transmit_select)));
  wire logic next_scl_oe = en & (m_scl_low | (~pin & bus_busy));
  // data may only move while SCL is low: an SDA edge under a high SCL is a start or stop
  wire logic data_oe     = bus_busy & (data_zero | ack_zero);
  wire logic next_sda_oe = en & (m_sda_low | (~in_stop & (scl_s ? sda_oe : data_oe)));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_START_BUSY: assert property (start_det |=> bus_busy)
    else $error("busy not set after start");
  AST_STOP_CLEARS: assert property (stop_det |=> !bus_busy && !master_select && !transmit_select)
    else $error("stop did not clear busy and mode bits");
  AST_IRQ_PIN: assert property (irq_ev && !data_acc && !ctlb_wr |=> !pin && transfer_irq)
    else $error("interrupt did not clear pending bit");
  AST_HOLD_SCL: assert property (!pin && bus_busy && en |=> scl_oe)
    else $error("scl not held low while pending bit is zero");
  AST_ACCESS_PIN: assert property (data_acc |=> pin && !self_addressed || $past(addr_phase_done))
    else $error("data access did not set pending bit");
  AST_NO_SW_CLEAR: assert property (ctlb_wr && !irq_ev |=> pin >= $past(pin))
    else $error("software cleared pending bit");
  AST_AL_DROP: assert property (al_ev |=> arbitration_lost && !master_select ##1 mstate == M_IDLE)
    else $error("arbitration loss did not drop master");
  AST_LRB: assert property (scl_rise |=> last_rx_bit == $past(sda_s))
    else $error("last received bit not captured");
  AST_GC_CLEAR: assert property (start_det |=> !zero_addr_seen)
    else $error("general call flag not cleared at start");
  AST_NOPIN: assert property (irq_nopin && !irq_ev && !data_acc |=> pin)
    else $error("pending bit cleared after lost arbitration");
  COV_START: cover property (mstate == M_START ##[1:300] start_det);
  COV_IRQ: cover property (transfer_irq && master_select);
  COV_AL: cover property (al_ev);
  COV_STOP: cover property (mstate == M_STOP_C ##[1:300] stop_det);
endmodule // i2c_bus_control_status

// *** shared/i2c_ctl_map.svh ***
// register offsets, bit positions, reset values and timing counts of the bus controller
`ifndef I2C_CTL_MAP_SVH
`define I2C_CTL_MAP_SVH
`define OFS_DATA   8'h00
`define OFS_CTLA   8'h04
`define OFS_CTLB   8'h08
`define OFS_STAT   8'h0c
`define OFS_OWN    8'h10
`define B_MST      7
`define B_TRX      6
`define B_BB       5
`define B_PIN      4
`define B_AL       3
`define B_AAS      2
`define B_AD0      1
`define B_LRB      0
`define PF_I2C     2'b10
`define PF_RST     2'b00
`define CTLA_RST   8'h00
`define OWN_RST    8'h00
`define PIN_RST    1'b1
`define RESP_OK    2'b00
`define RESP_ERR   2'b10
`define LOW_NS     5000
`define CLK_MHZ    40
`define LOW_CYC    ((`LOW_NS * `CLK_MHZ + 999) / 1000)
`endif

// *** shared/i2c_ctl_pkg.sv ***
// types shared by the bus controller
package i2c_ctl_pkg;
  typedef enum logic [2:0] {
    M_IDLE   = 3'b000,
    M_START  = 3'b001,
    M_LOW    = 3'b011,
    M_HIGH   = 3'b010,
    M_STOP_A = 3'b110,
    M_STOP_B = 3'b111,
    M_STOP_C = 3'b101
  } mstate_t;
  typedef logic [7:0] byte_t;
endpackage

// *** testbench/i2c_partner.sv ***
// bus partner: a target that acks one address, takes writes and returns a fixed byte
module i2c_partner #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       slow,
  input  wire logic [7:0] tx_byte,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic      [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic       rd;
  logic       sel;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // eight bits taken at rising edges, then wait for the fall
  task automatic get8(output logic [7:0] v);
    repeat (8) begin
      @(posedge scl);
      v = {v[6:0], sda};
    end
    @(negedge scl);
  endtask
  // ack slot; a slow target then stretches the low phase
  task automatic ack(input logic a);
    sda_oe = a;
    @(negedge scl);
    sda_oe = 1'b0;
    if (slow) begin
      scl_oe = 1'b1;
      #2000;
      scl_oe = 1'b0;
    end
  endtask
  // data changes only just after a fall, msb first, then the controller's ack
  task automatic put8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = !v[i];
      @(negedge scl);
    end
    sda_oe = 1'b0;
    @(posedge scl);
    sel = !sda;
    @(negedge scl);
  endtask
  task automatic xfer();
    get8(sh);
    sel = (sh[7:1] == ADDR);
    rd = sh[0];
    ack(sel);
    while (sel) begin
      if (rd) begin
        put8(tx_byte);
      end else begin
        get8(rx_byte);
        ack(1'b1);
      end
    end
  endtask
  // a stop ends the transaction wherever it stands, so no line is left held
  always begin
    @(negedge sda iff scl === 1'b1);
    fork
      xfer();
      @(posedge sda iff scl === 1'b1);
    join_any
    disable fork;
    sda_oe = 1'b0;
    scl_oe = 1'b0;
  end
endmodule // i2c_partner

// *** testbench/tb_i2c_bus_control_status.sv ***
// self-checking bench: register traffic over AXI4-Lite, transfers against a bus partner
`include "i2c_ctl_map.svh"
module tb_i2c_bus_control_status;
  import i2c_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOWC = 10;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  wire         awready, wready, bvalid, arready, rvalid, transfer_irq;
  wire         scl_oe, sda_oe, p_scl_oe, p_sda_oe;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  rx_byte;
  wire         scl = !(scl_oe | p_scl_oe);  // wired-and with pull-up
  wire         sda = !(sda_oe | p_sda_oe);
  int          fails = 0;
  int          num_checks = 0;
  logic [1:0]  resp;
  logic [7:0]  got;
  i2c_bus_control_status #(.LOW_CYC(LOWC)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .transfer_irq(transfer_irq));
  i2c_partner #(.ADDR(7'h50)) peer (
    .scl(scl), .sda(sda), .slow(slow), .tx_byte(8'ha5), .scl_oe(p_scl_oe),
    .sda_oe(p_sda_oe), .rx_byte(rx_byte));
  always #12.5 aclk = !aclk;
  task automatic complete_run();
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        resp = bresp;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        d = rdata[7:0];
        resp = rresp;
      end
    end
  endtask
  // bounded wait for the one-cycle transfer pulse
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (transfer_irq !== 1'b1 && n < 3000);
    chk("transfer_irq", 8'h01, {7'h0, transfer_irq});
  endtask
  task automatic start(input logic [7:0] a);
    wr(`OFS_DATA, a);
    wr(`OFS_CTLB, 8'hf8);
    wait_irq();
  endtask
  // stop, then poll until the busy flag drops
  task automatic stop();
    int n;
    n = 0;
    wr(`OFS_CTLB, 8'hd8);
    do begin
      rd(`OFS_STAT, got);
      n++;
    end while (got[`B_BB] !== 1'b0 && n < 100);
    chk("stat_stop", 8'h10, got);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFS_STAT, got);
    chk("stat_reset", 8'h10, got);
    wr(8'h14, 8'h00);
    chk_resp("bresp_unmapped", 2'b10, resp);
    rd(8'h14, got);
    chk_resp("rresp_unmapped", 2'b10, resp);
    wr(`OFS_OWN, 8'h64);
    wr(`OFS_CTLA, 8'h10);
    wr(`OFS_CTLB, 8'h18);
    rd(`OFS_CTLB, got);
    chk("ctlb_mode", 8'h18, got);
    start(8'ha0);
    rd(`OFS_STAT, got);
    chk("stat_wr_addr", 8'he0, got);
    wr(`OFS_CTLB, 8'he8);
    rd(`OFS_STAT, got);
    chk("stat_pin_kept", 8'he0, got);
    slow <= 1'b1;
    wr(`OFS_DATA, 8'h3c);
    wait_irq();
    chk("peer_rx", 8'h3c, rx_byte);
    slow <= 1'b0;
    stop();
    start(8'ha1);
    rd(`OFS_STAT, got);
    chk("stat_rd_addr", 8'ha0, got);
    rd(`OFS_DATA, got);
    wait_irq();
    rd(`OFS_STAT, got);
    chk("stat_rd_data", 8'ha0, got);
    stop();
    rd(`OFS_DATA, got);
    chk("rd_data", 8'ha5, got);
    start(8'hb0);
    rd(`OFS_STAT, got);
    chk("stat_nack", 8'he1, got);
    stop();
    complete_run();
  end
  // hang guard, well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    complete_run();
  end
endmodule // tb_i2c_bus_control_status
